// [design/dyn_start_channel.sv]
`timescale 1ns/1ns
`include "dyn_start_regs.svh"
module dyn_start_channel (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, low
    input wire logic tick, // monitoring cycle done
    input wire logic enable, // dynamic adjust on
    input wire logic offset64, // offset-64 coding
    input wire logic [9:0] temp, // code plus 2 fraction bits
    input wire dyn_start_pkg::chan_cfg_t cfg, // limits and code
    input wire logic sw_wr, // software write
    input wire logic [7:0] sw_data, // software data
    output logic [7:0] start_temp, // start temperature
    output logic below // temp below start
);
// code to signed degrees
function automatic logic signed [11:0] deg(input logic [7:0] c, input logic o);
    deg = o ? $signed({4'h0, c}) - `OFF64_BIAS : $signed({{4{c[7]}}, c});
endfunction
logic signed [11:0] t_q, prev_q, rise_q, start_d, op_d, low_d, high_d, hyst_d;
logic signed [11:0] floor_d, step, next_d, next_c;
logic [10:0] cyc_cnt, n_mask, l_mask;
logic short_c, long_c, active;
assign t_q = (deg(temp[9:2], offset64) <<< 2) + $signed({10'h0, temp[1:0]});
assign start_d = deg(start_temp, offset64);
assign op_d = deg(cfg.op, offset64);
assign low_d = deg(cfg.low, offset64);
assign high_d = deg(cfg.high, offset64);
assign hyst_d = $signed({8'h0, cfg.hyst});
assign floor_d = offset64 ? `FLOOR_OFF64 : `FLOOR_TWOS;
assign rise_q = t_q - prev_q;
// short every n, long every 2n monitoring cycles
assign n_mask = (`SHORT_N_MIN << cfg.code) - 11'h001;
assign l_mask = {n_mask[9:0], 1'b1};
assign short_c = tick && ((cyc_cnt & n_mask) == n_mask);
assign long_c = tick && ((cyc_cnt & l_mask) == l_mask);
// below start the loop is parked
assign active = enable && (t_q >= (start_d <<< 2));
// step and clamp; nothing happens inside the band
always_comb begin
    step = 12'sd0;
    if (short_c && t_q > ((op_d - hyst_d) <<< 2) && rise_q > `RISE_MIN_Q) begin
        step = step - (rise_q >>> 1);
    end
    if (long_c && t_q > (op_d <<< 2)) begin
        step = step - `LONG_STEP;
    end
    if (long_c && t_q < (low_d <<< 2) && start_d < high_d && start_d < op_d && t_q > (start_d <<< 2)) begin
        step = step + `LONG_STEP;
    end
    next_d = start_d + step;
    if (next_d > high_d) begin
        next_d = high_d;
    end
    if (next_d < floor_d) begin
        next_d = floor_d;
    end
    next_c = offset64 ? next_d + `OFF64_BIAS : next_d;
end
// cycle counter and previous sample
always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        cyc_cnt <= 11'h000;
        prev_q <= 12'sd0;
    end else if (tick) begin
        cyc_cnt <= cyc_cnt + 11'h001;
        prev_q <= t_q;
    end
end
// start temperature; software write wins over a step
always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        start_temp <= `RST_START;
    end else if (sw_wr) begin
        start_temp <= sw_data;
    end else if (active && step != 12'sd0) begin
        start_temp <= next_c[7:0];
    end
end
// fan off or minimum indication
always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        below <= 1'b0;
    end else begin
        below <= t_q < (start_d <<< 2);
    end
end
endmodule

// [design/dyn_start_pkg.sv]
package dyn_start_pkg;
typedef logic [7:0] temp_code_t;
typedef struct packed {
    temp_code_t op;
    temp_code_t low;
    temp_code_t high;
    logic [3:0] hyst;
    logic [2:0] code;
} chan_cfg_t;
typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] idx;
} ahb_req_t;
endpackage

// [design/dyn_start_regs.svh]
`ifndef DYN_START_REGS_SVH
`define DYN_START_REGS_SVH
// register indices; byte address is four times the index
`define IDX_TEMP_R1 8'h25
`define IDX_OP_R1 8'h33
`define IDX_CTRL1 8'h36
`define IDX_CTRL2 8'h37
`define IDX_LOW_R1 8'h4e
`define IDX_START_R1 8'h67
`define IDX_HYST_A 8'h6d
`define IDX_HYST_B 8'h6e
`define IDX_CONFIG 8'h7c
`define IDX_STATUS 8'h7d
// control one fields, channel order remote1, local, remote2; then the config register offset-64 bit
`define BIT_CYC_R2_LSB 0
`define BIT_CAP_BASE 2
`define BIT_DYN_BASE 5
`define BIT_OFFSET64 0
// reset values
`define RST_OP 8'ha4
`define RST_LOW 8'h01
`define RST_HIGH 8'h7f
`define RST_HYST_A 8'h44
`define RST_HYST_B 8'h40
`define RST_CTRL 8'h00
`define RST_START 8'h5a
// arithmetic constants, degrees, quarter degrees or monitoring cycles
`define FLOOR_TWOS (-12'sd127)
`define FLOOR_OFF64 (-12'sd64)
`define OFF64_BIAS 12'sd64
`define RISE_MIN_Q 12'sd1
`define LONG_STEP 12'sd1
`define SHORT_N_MIN 11'h008
`endif

// [design/dynamic_fan_start_temp_adjust.sv]
// What this block does
// - no start change while temp is inside operating band and above low limit
// - above op minus hysteresis, short cycle lowers start by twice the rise
// - rise of 0.25 degree or less since the previous monitoring cycle gives no reduction
// - above operating point, each long cycle lowers start by one degree more
// - between op minus hysteresis and op, long cycle changes nothing
// - long cycle raises start only when all four conditions hold
// - adjusted start never exceeds the channel high limit, except a limit below the floor, where the floor wins
// - start floor is -127 twos complement or -64 offset-64
// - temp below start parks fan and suspends adjustment
// - capture bit two copies remote1 temp to its op on overheat
// - capture bit three copies local temp to its op on overheat
// - capture bit four copies remote2 temp to its op on overheat
// - bit five enables remote1 dynamic adjust, else fixed
// - bit six enables local dynamic adjust, else fixed
// - bit seven enables remote2 dynamic adjust, else fixed
// - short cycle every n, long every 2n, n from 8 to 1024
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ns
`include "dyn_start_regs.svh"
module dynamic_fan_start_temp_adjust (
    input wire logic hclk, // bus clock
    input wire logic hresetn, // async reset, low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire logic overheat_pin_n, // async pin, low
    input wire logic monitor_done, // cycle end pulse
    input wire logic [9:0] temp_remote1, // remote1 reading
    input wire logic [9:0] temp_local, // local reading
    input wire logic [9:0] temp_remote2, // remote2 reading
    output logic [2:0][7:0] fan_start_temp, // per channel
    output logic [2:0] fan_below_start // per channel
);

// ----------------------------------------
// declarations
// ----------------------------------------
logic [9:0] temps [3];
logic [7:0] op_point [3];
logic [7:0] low_limit [3];
logic [7:0] high_limit [3];
logic [7:0] hyst_ab;
logic [7:0] hyst_c;
logic [7:0] ctrl_one;
logic [7:0] ctrl_two;
logic [7:0] config_reg;
logic [3:0] hyst_sel [3];
logic [2:0] code_sel [3];
logic [2:0] start_wr;
logic ovh_meta;
logic ovh_sync;
logic overheat_act;
dyn_start_pkg::ahb_req_t req;
dyn_start_pkg::ahb_req_t next_req;
logic addr_ok;
logic wr_phase;
logic rd_wait;
logic [7:0] wr_byte;
logic [31:0] next_rdata;

assign temps[0] = temp_remote1;
assign temps[1] = temp_local;
assign temps[2] = temp_remote2;

// ----------------------------------------
// overheat pin synchroniser
// ----------------------------------------
// two stages; only the second is looked at
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ovh_meta <= 1'b1;
        ovh_sync <= 1'b1;
    end else begin
        ovh_meta <= overheat_pin_n;
        ovh_sync <= ovh_meta;
    end
end

// pin is active low
assign overheat_act = !ovh_sync;

// ----------------------------------------
// bus address phase
// ----------------------------------------
// word aligned, inside the small window of indices
assign addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00);

// a request is taken when selected, nonseq or seq, and bus ready
always_comb begin
    next_req.sel = hsel && htrans[1] && hready;
    next_req.write = hwrite;
    next_req.idx = addr_ok ? haddr[9:2] : 8'h00;
end

// hold the address phase for the data phase
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        req <= '0;
    end else if (hready) begin
        req <= next_req;
    end
end

// write lands in the data phase, registers take it at its end
assign wr_phase = req.sel && req.write;
assign wr_byte = hwdata[7:0];

// ----------------------------------------
// bus ready and response
// ----------------------------------------
// reads take one wait state so a write just before is visible
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hreadyout <= 1'b1;
        rd_wait <= 1'b0;
    end else if (next_req.sel && !next_req.write) begin
        hreadyout <= 1'b0;
        rd_wait <= 1'b1;
    end else begin
        hreadyout <= 1'b1;
        rd_wait <= 1'b0;
    end
end

// no error cases; unmapped space reads zero
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hresp <= 1'b0;
    end else begin
        hresp <= 1'b0;
    end
end

// ----------------------------------------
// shared control registers
// ----------------------------------------
// control one: capture and enable bits, cycle code lsb
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ctrl_one <= `RST_CTRL;
    end else if (wr_phase && req.idx == `IDX_CTRL1) begin
        ctrl_one <= wr_byte;
    end
end

// control two: cycle codes
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ctrl_two <= `RST_CTRL;
    end else if (wr_phase && req.idx == `IDX_CTRL2) begin
        ctrl_two <= wr_byte;
    end
end

// hysteresis for remote1 and local
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hyst_ab <= `RST_HYST_A;
    end else if (wr_phase && req.idx == `IDX_HYST_A) begin
        hyst_ab <= wr_byte;
    end
end

// hysteresis for remote2, upper nibble only
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hyst_c <= `RST_HYST_B;
    end else if (wr_phase && req.idx == `IDX_HYST_B) begin
        hyst_c <= {wr_byte[7:4], 4'h0};
    end
end

// coding select; changing it does not recode stored values
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        config_reg <= `RST_CTRL;
    end else if (wr_phase && req.idx == `IDX_CONFIG) begin
        config_reg <= {7'h00, wr_byte[`BIT_OFFSET64]};
    end
end

// per channel field selection
assign hyst_sel[0] = hyst_ab[7:4];
assign hyst_sel[1] = hyst_ab[3:0];
assign hyst_sel[2] = hyst_c[7:4];
assign code_sel[0] = ctrl_two[2:0];
assign code_sel[1] = ctrl_two[5:3];
assign code_sel[2] = {ctrl_two[7:6], ctrl_one[`BIT_CYC_R2_LSB]};

// ----------------------------------------
// per channel registers and adjusters
// ----------------------------------------
for (genvar g = 0; g < 3; g++) begin : gen_chan
    localparam logic [7:0] OP_IDX = `IDX_OP_R1 + 8'(g);
    localparam logic [7:0] LOW_IDX = `IDX_LOW_R1 + 8'(2 * g);
    localparam logic [7:0] HIGH_IDX = `IDX_LOW_R1 + 8'(2 * g + 1);
    localparam logic [7:0] START_IDX = `IDX_START_R1 + 8'(g);
    dyn_start_pkg::chan_cfg_t cfg;

    // overheat capture beats a software write in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_point[g] <= `RST_OP;
        end else if (overheat_act && ctrl_one[`BIT_CAP_BASE + g]) begin
            op_point[g] <= temps[g][9:2];
        end else if (wr_phase && req.idx == OP_IDX) begin
            op_point[g] <= wr_byte;
        end
    end

    // low limit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_limit[g] <= `RST_LOW;
        end else if (wr_phase && req.idx == LOW_IDX) begin
            low_limit[g] <= wr_byte;
        end
    end

    // high limit, also the upper clamp
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_limit[g] <= `RST_HIGH;
        end else if (wr_phase && req.idx == HIGH_IDX) begin
            high_limit[g] <= wr_byte;
        end
    end

    assign start_wr[g] = wr_phase && req.idx == START_IDX;
    assign cfg.op = op_point[g];
    assign cfg.low = low_limit[g];
    assign cfg.high = high_limit[g];
    assign cfg.hyst = hyst_sel[g];
    assign cfg.code = code_sel[g];

    // one adjuster per channel, own limits and cycle code
    dyn_start_channel u_chan (
        .clk(hclk),
        .rst_n(hresetn),
        .tick(monitor_done),
        .enable(ctrl_one[`BIT_DYN_BASE + g]),
        .offset64(config_reg[`BIT_OFFSET64]),
        .temp(temps[g]),
        .cfg(cfg),
        .sw_wr(start_wr[g]),
        .sw_data(wr_byte),
        .start_temp(fan_start_temp[g]),
        .below(fan_below_start[g])
    );
end

// ----------------------------------------
// read path
// ----------------------------------------
// decoded during the wait state, after any prior write
always_comb begin
    next_rdata = 32'h0000_0000;
    for (int i = 0; i < 3; i++) begin
        if (req.idx == `IDX_OP_R1 + 8'(i)) begin
            next_rdata = {24'h0, op_point[i]};
        end
        if (req.idx == `IDX_LOW_R1 + 8'(2 * i)) begin
            next_rdata = {24'h0, low_limit[i]};
        end
        if (req.idx == `IDX_LOW_R1 + 8'(2 * i + 1)) begin
            next_rdata = {24'h0, high_limit[i]};
        end
        if (req.idx == `IDX_START_R1 + 8'(i)) begin
            next_rdata = {24'h0, fan_start_temp[i]};
        end
        if (req.idx == `IDX_TEMP_R1 + 8'(i)) begin
            next_rdata = {24'h0, temps[i][9:2]};
        end
    end
    case (req.idx)
        `IDX_CTRL1: begin
            next_rdata = {24'h0, ctrl_one};
        end
        `IDX_CTRL2: begin
            next_rdata = {24'h0, ctrl_two};
        end
        `IDX_HYST_A: begin
            next_rdata = {24'h0, hyst_ab};
        end
        `IDX_HYST_B: begin
            next_rdata = {24'h0, hyst_c};
        end
        `IDX_CONFIG: begin
            next_rdata = {24'h0, config_reg};
        end
        `IDX_STATUS: begin
            next_rdata = {29'h0, fan_below_start};
        end
        default: begin
        end
    endcase
end

// read data stands from the wait state until the next read
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata <= 32'h0000_0000;
    end else if (rd_wait) begin
        hrdata <= next_rdata;
    end
end

endmodule

// [tb/cpu_hot_model.sv]
`timescale 1ns/1ns
module cpu_hot_model (
    input wire logic clk, // bus clock
    input wire logic hot, // bench asks for throttling
    output logic cpu_hot_signal_n // active-low line, driven both ways
);
    // drives low while hot and high otherwise, on each rising clock edge; no pull-up is modelled
    // one driver only; the design holds its sync flops high through reset
    always @(posedge clk) begin
        cpu_hot_signal_n <= !hot;
    end
endmodule

// [tb/fan_start_checker.sv]
`timescale 1ns/1ns
module fan_start_checker (
    input wire logic hclk, // bus clock
    input wire logic hresetn, // async reset, low
    input wire logic hsel, // slave select
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic hready, // bus ready
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic monitor_done, // cycle end pulse
    input wire logic [9:0] temp_remote1, // remote1 reading
    input wire logic [2:0][7:0] fan_start_temp, // per channel
    input wire logic [2:0] fan_below_start // per channel
);
    logic take;
    logic wr_take;
    logic [7:0] t1_int;
    logic [2:0] tcnt;
    // ----
    // helpers
    // ----
    // accepted transfers and integer part of the reading
    assign take = hsel && htrans[1] && hready;
    assign wr_take = take && hwrite;
    assign t1_int = temp_remote1[9:2];
    // low tick bits suffice: every cycle length is a multiple of eight
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tcnt <= 3'h0;
        end else if (monitor_done) begin
            tcnt <= tcnt + 3'h1;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----
    // properties; signed checks assume twos complement coding
    // ----
    a_start_moves: assert property ($changed(fan_start_temp) |->
        ($past(monitor_done) && $past(tcnt) == 3'h7) || $past(wr_take, 2))
        else $error("start temperature moved outside a short cycle");
    a_raise_step: assert property ($past(monitor_done) && !$past(wr_take, 2) &&
        $signed(fan_start_temp[0]) > $signed($past(fan_start_temp[0]))
        |-> fan_start_temp[0] == $past(fan_start_temp[0]) + 8'h01)
        else $error("start temperature rose by more than one");
    a_floor_hold: assert property ($past(monitor_done) && !$past(wr_take, 2) &&
        $changed(fan_start_temp[0]) |-> $signed(fan_start_temp[0]) >= -8'sd127)
        else $error("start temperature below floor");
    a_below_flag: assert property ($past(hresetn) |-> fan_below_start[0] ==
        ($signed($past(t1_int)) < $signed($past(fan_start_temp[0]))))
        else $error("below flag wrong");
    a_suspend_below: assert property ($past(monitor_done) && !$past(wr_take, 2) &&
        $signed($past(t1_int)) < $signed($past(fan_start_temp[0])) |-> $stable(fan_start_temp[0]))
        else $error("adjusted while below start");
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait not one cycle");
    a_write_nowait: assert property (wr_take |=> hreadyout)
        else $error("write stalled");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    c_step: cover property ($past(monitor_done) && $changed(fan_start_temp[0]));
    c_below: cover property (fan_below_start[0]);
    c_read: cover property (take && !hwrite);
endmodule
bind dynamic_fan_start_temp_adjust fan_start_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .monitor_done(monitor_done), .temp_remote1(temp_remote1), .fan_start_temp(fan_start_temp),
    .fan_below_start(fan_below_start));

// [tb/tb_dynamic_fan_start_temp_adjust.sv]
`timescale 1ns/1ns
`include "dyn_start_regs.svh"
module tb_dynamic_fan_start_temp_adjust;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic monitor_done = 1'b0;
    logic hot = 1'b0;
    logic pin_n;
    logic [9:0] tr1 = 10'h0;
    logic [9:0] tl = 10'h0;
    logic [9:0] tr2 = 10'h0;
    logic [2:0][7:0] start;
    logic [2:0] below;
    logic [31:0] rv;
    int n_fail = 0;
    int checks_done = 0;
    int tcnt = 0;
    localparam logic [7:0] rst_ix [8] = '{8'h36, 8'h33, 8'h34, 8'h4e, 8'h4f, 8'h6d, 8'h6e, 8'h37};
    localparam logic [7:0] rst_val [8] = '{8'h00, 8'ha4, 8'ha4, 8'h01, 8'h7f, 8'h44, 8'h40, 8'h00};
    localparam logic [9:0] sh_base [4] = '{10'h078, 10'h07c, 10'h07e, 10'h050};
    localparam logic [9:0] sh_rise [4] = '{10'h4, 10'h2, 10'h1, 10'h4};
    localparam logic [7:0] sh_drop [4] = '{8'h2, 8'h1, 8'h0, 8'h0};
    // rows: low, op, high, start, temp, expected start
    localparam logic [47:0] rz [5] = '{48'h20307f101811, 48'h203010101810, 48'h20107f10180f,
        48'h20307f100c10, 48'h80847f818881};

    dynamic_fan_start_temp_adjust u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .overheat_pin_n(pin_n),
        .monitor_done(monitor_done), .temp_remote1(tr1), .temp_local(tl), .temp_remote2(tr2),
        .fan_start_temp(start), .fan_below_start(below));
    cpu_hot_model u_hot (.clk(hclk), .hot(hot), .cpu_hot_signal_n(pin_n));

    // ----
    // clock and helpers
    // ----
    initial begin
        forever #2 hclk = ~hclk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // single word transfer; waits on hready rather than a fixed latency
    task xfer(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask
    task w8(input logic [7:0] i, input logic [7:0] d);
        xfer(1'b1, {i, 2'h0}, d);
    endtask
    task r8(input logic [7:0] i);
        xfer(1'b0, {i, 2'h0}, 8'h00);
    endtask
    task tick(input int n);
        repeat (n) begin
            @(posedge hclk);
            monitor_done <= 1'b1;
            @(posedge hclk);
            monitor_done <= 1'b0;
            tcnt++;
        end
        @(negedge hclk);
    endtask
    // adjust off while aligning, so the previous reading equals the present one
    task setup(input logic [7:0] c1, c2, op, lo, hi, st, input int m, r);
        w8(`IDX_CTRL1, 8'h00);
        do tick(1); while (tcnt % m != r);
        w8(`IDX_OP_R1, op);
        w8(`IDX_LOW_R1, lo);
        w8(`IDX_LOW_R1 + 8'h1, hi);
        w8(`IDX_START_R1, st);
        w8(`IDX_CTRL2, c2);
        w8(`IDX_CTRL1, c1);
    endtask
    // ----
    // scenarios
    // ----
    task t_regs();
        foreach (rst_ix[k]) begin
            r8(rst_ix[k]);
            check(rv, {24'h0, rst_val[k]});
        end
        w8(`IDX_CTRL2, 8'ha5);
        r8(`IDX_CTRL2);
        check(rv, 32'ha5);
        xfer(1'b1, 10'h0d9, 8'h55);
        xfer(1'b0, 10'h0d9, 8'h00);
        check(rv, 32'h0);
        r8(`IDX_CTRL1);
        check(rv, 32'h0);
    endtask
    task t_long(input logic [2:0] code);
        int n;
        logic [7:0] e;
        n = 8 << code;
        tr1 <= 10'h0c0;
        tl <= 10'h1c0;
        tr2 <= 10'h1c0;
        setup(8'h20, {5'h0, code}, 8'h20, 8'h01, 8'h7f, 8'h28, 1, 0);
        e = 8'h28;
        repeat (2 * n) begin
            tick(1);
            e = e - {7'h0, tcnt % (2 * n) == 0};
            check(start[0], e);
            check(start[2:1], 16'h5a5a);
        end
    endtask
    task t_short();
        logic [7:0] e;
        e = 8'h10;
        foreach (sh_base[k]) begin
            tr1 <= sh_base[k];
            setup(8'h20, 8'h00, 8'h20, 8'h01, 8'h7f, e, 8, 7);
            tr1 <= sh_base[k] + sh_rise[k];
            tick(1);
            e = e - sh_drop[k];
            check(start[0], e);
        end
    endtask
    task t_raise();
        logic [47:0] r;
        foreach (rz[k]) begin
            r = rz[k];
            tr1 <= {r[15:8], 2'h0};
            setup(8'h20, 8'h00, r[39:32], r[47:40], r[31:24], r[23:16], 16, 15);
            tick(1);
            check(start[0], r[7:0]);
            @(negedge hclk);
            check(below[0], $signed(r[15:8]) < $signed(r[7:0]));
        end
    endtask
    task t_capture();
        tr1 <= 10'h0ab;
        tl <= 10'h0af;
        tr2 <= 10'h0b3;
        for (int i = 0; i < 4; i++) begin
            w8(`IDX_CTRL1, i < 3 ? 8'h04 << i : 8'h00);
            for (int k = 0; k < 3; k++) begin
                w8(`IDX_OP_R1 + k[7:0], 8'h11);
            end
            hot <= 1'b1;
            repeat (6) @(posedge hclk);
            hot <= 1'b0;
            repeat (6) @(posedge hclk);
            for (int k = 0; k < 3; k++) begin
                r8(`IDX_OP_R1 + k[7:0]);
                check(rv, (k == i) ? 32'h2a + k : 32'h11);
            end
        end
    endtask
    // offset-64 coding: op 0x7c is 60 degrees here but 124 in twos complement
    // all codes but op kept in the upper half so the checker's signed view agrees
    task t_off64();
        tr1 <= 10'h240;
        w8(`IDX_CONFIG, 8'h01);
        setup(8'h20, 8'h00, 8'h7c, 8'h81, 8'hff, 8'h88, 16, 15);
        tick(1);
        check(start[0], 8'h87);
        check(below[0], 1'b0);
    endtask
    // ----
    // sequence and verdict
    // ----
    task results();
        if (n_fail == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_long(3'h0);
        t_long(3'h1);
        t_long(3'h7);
        t_short();
        t_raise();
        t_capture();
        t_off64();
        results();
    end
    // about five thousand cycles expected; a hang ends here
    initial begin
        #200000;
        n_fail++;
        results();
    end
endmodule
